// ### core/param_bank_pkg.sv
// Constants shared by the drive parameter bank
`default_nettype none
package param_bank_pkg;
  // ==========================================================
  // Register indices (service data index numbers)
  localparam logic [7:0]  IDX_GP_FIRST   = 8'hab;
  localparam logic [7:0]  IDX_GP_LAST    = 8'hb4;
  localparam logic [7:0]  IDX_VOLT_LIM   = 8'hb5;
  localparam logic [7:0]  IDX_TEMP_LIM   = 8'hb6;
  localparam logic [7:0]  IDX_CMD        = 8'hc1;
  localparam int          GP_COUNT       = 10;
  // ==========================================================
  // Reset values and legal ranges
  localparam logic [15:0] GP_RESET       = 16'h0000;
  localparam logic [15:0] VOLT_LIM_RESET = 16'h00b9;
  localparam logic [15:0] VOLT_LIM_MIN   = 16'h00b4;
  localparam logic [15:0] VOLT_LIM_MAX   = 16'h00f0;
  localparam logic [15:0] TEMP_LIM_RESET = 16'h0046;
  localparam logic [15:0] TEMP_LIM_MIN   = 16'h000a;
  localparam logic [15:0] TEMP_LIM_MAX   = 16'h0046;
  // ==========================================================
  // Command codes (16-bit two's complement)
  localparam logic [15:0] CMD_NONE       = 16'h0000;
  localparam logic [15:0] CMD_SAVE       = 16'h0001;
  localparam logic [15:0] CMD_FACT_FMT1  = 16'h0002;
  localparam logic [15:0] CMD_FACT_KEEP  = 16'h0003;
  localparam logic [15:0] CMD_FACT_REF   = 16'hffff;
  localparam logic [15:0] CMD_FACT_ALL   = 16'hfffe;
  // Result codes read back from the command register
  localparam logic [15:0] RES_OK         = 16'h0000;
  localparam logic [15:0] RES_BUSY       = 16'h0001;
  localparam logic [15:0] RES_FAIL       = 16'h0002;
  // ==========================================================
  // Process-data format selector: 0 six-byte, 1 time stamp
  localparam logic        FMT_SIX_BYTE   = 1'b0;
  localparam logic        FMT_TIME_STAMP = 1'b1;
  // Save timing
  localparam int          CLK_HZ         = 50_000_000;
  localparam int          SAVE_LIMIT_MS  = 2000;
  localparam longint      SAVE_LIMIT_CYC =
    longint'(SAVE_LIMIT_MS) * longint'(CLK_HZ) / 1000;
endpackage : param_bank_pkg
`default_nettype wire

// ### core/save_sequencer.sv
// Sequencer for storing the parameter set into nonvolatile memory
`default_nettype none
module save_sequencer
  import param_bank_pkg::*;
#(
  parameter int TIMEOUT_CYC = 100_000_000
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        start,
  output logic             nv_req,
  input  wire logic        nv_done,
  input  wire logic        nv_error,
  output logic             busy,
  output logic             failed
);
  typedef enum {S_IDLE, S_WAIT} sq_state_t;
  typedef struct packed {
    sq_state_t   st;
    logic [31:0] cnt;
    logic        failed;
  } sq_t;
  sq_t q, d;

  // ==========================================================
  // Handshake with the memory; timeout marks a failure
  always_comb begin
    d = q;
    unique case (q.st)
      S_IDLE: begin
        if (start) begin
          d.st     = S_WAIT;
          d.cnt    = '0;
          d.failed = 1'b0;
        end
      end
      S_WAIT: begin
        d.cnt = q.cnt + 32'h1;
        if (nv_done || nv_error || q.cnt == 32'(TIMEOUT_CYC - 1)) begin
          d.st     = S_IDLE;
          d.failed = ~nv_done | nv_error;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{st: S_IDLE, cnt: 32'h0, failed: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign nv_req = (q.st == S_WAIT);
  assign busy   = (q.st == S_WAIT);
  assign failed = q.failed;
endmodule : save_sequencer
`default_nettype wire

// ### core/drive_parameter_bank.sv
// Parameter bank with thresholds, factory restore and save command
// ============================================================
// Behaviour
// - Motor voltage limit in 0.1 V sets power-present flag, reset 185.
// - Temperature limit in deg C sets overtemperature flag, reset 70.
// - Writing -1 restores values except format, then refs and centres.
// - Writing -2 restores all incl. format, then refs and centres.
// - A restored format only becomes active after reset or restart.
// - Writing 1 saves the parameter set to nonvolatile memory.
// - Writing 0 does nothing.
// - Writing 2 restores factory values, format 1, no ref, no centre.
// - Writing 3 restores values, keeps format, no ref, no centre.
// - After boot the command register reads zero if memory is correct.
// - After a successful save the command register reads zero.
// - Reads nonzero while saving or on failure; save may take 2000 ms.
// - Format picks time-stamp or six-byte layout, six-byte by default.
`default_nettype none
module drive_parameter_bank
  import param_bank_pkg::*;
#(
  parameter longint SAVE_TIMEOUT_CYC = SAVE_LIMIT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  index,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  output logic             wr_ack,
  output logic             wr_reject,
  input  wire logic        boot_mem_ok,
  input  wire logic [15:0] motor_supply_voltage,
  input  wire logic [15:0] temperature,
  input  wire logic        fmt_stored,
  output logic             motor_power_present,
  output logic             overtemperature,
  output logic             fmt_active,
  output logic             fmt_pending,
  output logic             ref_loop_start,
  output logic             centre_start,
  input  wire logic        restart_cmd,
  output logic             nv_req,
  input  wire logic        nv_done,
  input  wire logic        nv_error
);
  typedef struct packed {
    logic [GP_COUNT-1:0][15:0] gp;
    logic [15:0]               volt_lim;
    logic [15:0]               temp_lim;
    logic [15:0]               cmd_res;
    logic                      fmt_pend;
    logic                      fmt_act;
    logic                      boot_done;
    logic                      ref_p;
    logic                      ctr_p;
    logic                      save_go;
    logic                      saving;
    logic [15:0]               rdat;
    logic                      rval;
    logic                      ack;
    logic                      rej;
    logic                      mp;
    logic                      ot;
  } bank_t;
  bank_t q, d;

  logic sq_busy;
  logic sq_failed;

  // All checks run on the one system clock
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // Free-use window decode
  function automatic logic is_gp(input logic [7:0] i);
    return i >= IDX_GP_FIRST && i <= IDX_GP_LAST;
  endfunction : is_gp

  // Range check per register; unmapped index is not in range
  function automatic logic in_range(input logic [7:0] i,
                                    input logic [15:0] v);
    if (is_gp(i)) return 1'b1;
    if (i == IDX_VOLT_LIM)
      return v >= VOLT_LIM_MIN && v <= VOLT_LIM_MAX;
    if (i == IDX_TEMP_LIM)
      return v >= TEMP_LIM_MIN && v <= TEMP_LIM_MAX;
    if (i == IDX_CMD)
      return v == CMD_NONE || v == CMD_SAVE || v == CMD_FACT_FMT1 ||
             v == CMD_FACT_KEEP || v == CMD_FACT_REF ||
             v == CMD_FACT_ALL;
    return 1'b0;
  endfunction : in_range

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] gi;
    gi = 8'(index - IDX_GP_FIRST);
    d = q;
    d.ref_p   = 1'b0;
    d.ctr_p   = 1'b0;
    d.save_go = 1'b0;
    d.ack     = 1'b0;
    d.rej     = 1'b0;
    d.rval    = 1'b0;
    // Start pulse leads busy by one cycle; bridge it so no early result
    d.saving  = sq_busy | q.save_go;
    // Strap sampled after reset release, not in the reset branch
    if (!q.boot_done) begin
      d.boot_done = 1'b1;
      d.fmt_act   = fmt_stored;
      d.fmt_pend  = fmt_stored;
      d.cmd_res   = boot_mem_ok ? RES_OK : RES_FAIL;
    end
    if (restart_cmd) begin
      d.fmt_act = q.fmt_pend;
    end
    // Save result follows the sequencer
    if (q.saving && !sq_busy && !q.save_go) begin
      d.cmd_res = sq_failed ? RES_FAIL : RES_OK;
    end
    if (wr_en) begin
      if (!in_range(index, wr_data)) begin
        d.rej = 1'b1;
      end else begin
        d.ack = 1'b1;
        if (is_gp(index)) begin
          d.gp[gi[3:0]] = wr_data;
        end else if (index == IDX_VOLT_LIM) begin
          d.volt_lim = wr_data;
        end else if (index == IDX_TEMP_LIM) begin
          d.temp_lim = wr_data;
        end else if (wr_data == CMD_SAVE) begin
          d.save_go = 1'b1;
          d.saving  = 1'b1;
          d.cmd_res = RES_BUSY;
        end else if (wr_data != CMD_NONE) begin
          // Factory restore; format change waits for restart
          d.gp       = {GP_COUNT{GP_RESET}};
          d.volt_lim = VOLT_LIM_RESET;
          d.temp_lim = TEMP_LIM_RESET;
          if (wr_data == CMD_FACT_ALL) begin
            d.fmt_pend = FMT_SIX_BYTE;
          end else if (wr_data == CMD_FACT_FMT1) begin
            d.fmt_pend = FMT_TIME_STAMP;
          end
          if (wr_data == CMD_FACT_REF || wr_data == CMD_FACT_ALL) begin
            d.ref_p = 1'b1;
            d.ctr_p = 1'b1;
          end
          // code 3 keeps format and skips ref and centre
        end
      end
    end
    if (rd_en) begin
      d.rval = 1'b1;
      d.rdat = 16'h0000;
      if (is_gp(index)) begin
        d.rdat = q.gp[gi[3:0]];
      end else if (index == IDX_VOLT_LIM) begin
        d.rdat = q.volt_lim;
      end else if (index == IDX_TEMP_LIM) begin
        d.rdat = q.temp_lim;
      end else if (index == IDX_CMD) begin
        d.rdat = q.cmd_res;
      end
    end
    d.mp = motor_supply_voltage >= q.volt_lim;
    d.ot = temperature > q.temp_lim;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q          <= '0;
      q.gp       <= {GP_COUNT{GP_RESET}};
      q.volt_lim <= VOLT_LIM_RESET;
      q.temp_lim <= TEMP_LIM_RESET;
      q.cmd_res  <= RES_BUSY;
      q.fmt_pend <= FMT_SIX_BYTE;
      q.fmt_act  <= FMT_SIX_BYTE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Save sequencer
  // A memory that never answers ends as a failed save
  save_sequencer #(
    .TIMEOUT_CYC (int'(SAVE_TIMEOUT_CYC))
  ) u_save (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .start    (q.save_go),
    .nv_req   (nv_req),
    .nv_done  (nv_done),
    .nv_error (nv_error),
    .busy     (sq_busy),
    .failed   (sq_failed)
  );

  assign rd_data             = q.rdat;
  assign rd_valid            = q.rval;
  assign wr_ack              = q.ack;
  assign wr_reject           = q.rej;
  assign motor_power_present = q.mp;
  assign overtemperature     = q.ot;
  assign fmt_active          = q.fmt_act;
  assign fmt_pending         = q.fmt_pend;
  assign ref_loop_start      = q.ref_p;
  assign centre_start        = q.ctr_p;

  // ==========================================================
  // Checks: thresholds, boot and readback
  a_volt_flag: assert property (
    1'b1 |=> motor_power_present ==
      ($past(motor_supply_voltage) >= $past(q.volt_lim)))
    else $error("power flag mismatch");
  a_temp_flag: assert property (
    1'b1 |=> overtemperature == ($past(temperature) > $past(q.temp_lim)))
    else $error("overtemp flag mismatch");
  a_read_valid: assert property (
    rd_en |=> rd_valid)
    else $error("read not answered");
  a_boot_ok: assert property (
    !q.boot_done && boot_mem_ok |=> q.cmd_res == RES_OK)
    else $error("boot result not zero");
  a_fmt_default: assert property (
    !q.boot_done |-> fmt_active == FMT_SIX_BYTE)
    else $error("format not six-byte at boot");

  // ==========================================================
  // Checks: commands and format
  a_fact_ref: assert property (
    wr_en && index == IDX_CMD && wr_data == CMD_FACT_REF
      |=> ref_loop_start && centre_start && q.volt_lim == VOLT_LIM_RESET)
    else $error("restore -1 failed");
  a_fact_all: assert property (
    wr_en && index == IDX_CMD && wr_data == CMD_FACT_ALL
      |=> ref_loop_start && fmt_pending == FMT_SIX_BYTE)
    else $error("restore -2 failed");
  a_pulse_pair: assert property (
    ref_loop_start == centre_start)
    else $error("reference and centre apart");
  a_fmt_defer: assert property (
    q.boot_done && !restart_cmd |=> $stable(fmt_active))
    else $error("format changed early");
  a_fmt_restart: assert property (
    q.boot_done && restart_cmd |=> fmt_active == $past(fmt_pending))
    else $error("format not taken on restart");
  a_no_action: assert property (
    wr_en && index == IDX_CMD && wr_data == CMD_NONE
      |=> !ref_loop_start && !q.save_go && $stable(q.gp))
    else $error("zero command acted");
  a_fact_fmt1: assert property (
    wr_en && index == IDX_CMD && wr_data == CMD_FACT_FMT1
      |=> !ref_loop_start && fmt_pending == FMT_TIME_STAMP)
    else $error("restore 2 failed");
  a_fact_keep: assert property (
    wr_en && index == IDX_CMD && wr_data == CMD_FACT_KEEP
      |=> !centre_start && $stable(fmt_pending))
    else $error("restore 3 failed");
  a_keep_values: assert property (
    wr_en && index == IDX_CMD && wr_data == CMD_FACT_KEEP
      |=> q.gp == {GP_COUNT{GP_RESET}} && q.temp_lim == TEMP_LIM_RESET)
    else $error("restore 3 left values");

  // ==========================================================
  // Checks: save and range
  a_save_go: assert property (
    wr_en && index == IDX_CMD && wr_data == CMD_SAVE |=> ##1 nv_req)
    else $error("save not started");
  a_save_ok: assert property (
    q.saving && !sq_busy && !q.save_go && !sq_failed
      |=> q.cmd_res == RES_OK)
    else $error("save ok not reported");
  a_save_busy: assert property (
    sq_busy |-> q.cmd_res != RES_OK)
    else $error("zero during save");
  a_busy_read: assert property (
    rd_en && index == IDX_CMD && sq_busy |=> rd_data != RES_OK)
    else $error("zero read during save");
  a_save_fail: assert property (
    q.saving && !sq_busy && !q.save_go && sq_failed
      |=> q.cmd_res == RES_FAIL)
    else $error("save failure not reported");
  a_reject: assert property (
    wr_en && index == IDX_TEMP_LIM && wr_data > TEMP_LIM_MAX
      |=> wr_reject && $stable(q.temp_lim))
    else $error("bad write taken");
  a_reject_any: assert property (
    wr_en && !in_range(index, wr_data) |=> wr_reject && !wr_ack)
    else $error("out-of-range write acked");
  a_volt_range: assert property (
    q.volt_lim >= VOLT_LIM_MIN && q.volt_lim <= VOLT_LIM_MAX)
    else $error("voltage limit out of range");

  // Main scenarios
  c_save: cover property (@(posedge clk_sys) q.saving && !sq_busy);
  c_save_fail: cover property (@(posedge clk_sys) nv_error);
  c_reject: cover property (@(posedge clk_sys) wr_reject);
  c_restore: cover property (@(posedge clk_sys) ref_loop_start);
  c_restart: cover property (@(posedge clk_sys) restart_cmd && fmt_pending);
endmodule : drive_parameter_bank
`default_nettype wire

// ### bench/nv_memory_model.sv
// Behavioural nonvolatile memory answering save requests
`default_nettype none
module nv_memory_model (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic nv_req,
  input  wire logic fail_mode,
  input  wire logic slow_mode,
  input  wire logic mute_mode,
  output logic      nv_done,
  output logic      nv_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] wait_q;
  logic       answered_q;
  // ========================================
  // Answer
  // One answer per request; slow answer still beats the save timeout
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wait_q     <= 6'h00;
      answered_q <= 1'b0;
      nv_done    <= 1'b0;
      nv_error   <= 1'b0;
    end else begin
      nv_done  <= 1'b0;
      nv_error <= 1'b0;
      if (!nv_req) begin
        wait_q     <= 6'h00;
        answered_q <= 1'b0;
      end else if (!answered_q) begin
        wait_q <= wait_q + 6'h01;
        // Mute mode never answers, so the save runs into its timeout
        if (!mute_mode && wait_q == (slow_mode ? 6'h1e : 6'h02)) begin
          nv_done    <= !fail_mode;
          nv_error   <= fail_mode;
          answered_q <= 1'b1;
        end
      end
    end
  end
endmodule : nv_memory_model
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking testbench of the drive parameter bank
`default_nettype none
module tb_top;
  import param_bank_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] index = 8'h00;
  logic [15:0] wr_data = 16'h0000, rd_data;
  logic [15:0] motor_supply_voltage = 16'h0000, temperature = 16'h0000;
  logic boot_mem_ok = 1'b1, fmt_stored = 1'b0, restart_cmd = 1'b0;
  logic fail_mode = 1'b0, slow_mode = 1'b0, mute_mode = 1'b0;
  logic rd_valid, wr_ack, wr_reject, motor_power_present;
  logic overtemperature, fmt_active, fmt_pending, ref_loop_start;
  logic centre_start, nv_req, nv_done, nv_error;
  int error_cnt = 0;
  int check_count = 0;
  always #10 clk_sys = ~clk_sys;
  drive_parameter_bank #(.SAVE_TIMEOUT_CYC(50)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en),
    .index(index), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .wr_ack(wr_ack), .wr_reject(wr_reject),
    .boot_mem_ok(boot_mem_ok), .motor_supply_voltage(motor_supply_voltage),
    .temperature(temperature), .fmt_stored(fmt_stored),
    .motor_power_present(motor_power_present),
    .overtemperature(overtemperature), .fmt_active(fmt_active),
    .fmt_pending(fmt_pending), .ref_loop_start(ref_loop_start),
    .centre_start(centre_start), .restart_cmd(restart_cmd),
    .nv_req(nv_req), .nv_done(nv_done), .nv_error(nv_error));
  nv_memory_model partner (
    .clk_sys(clk_sys), .reset_n(reset_n), .nv_req(nv_req),
    .fail_mode(fail_mode), .slow_mode(slow_mode), .mute_mode(mute_mode),
    .nv_done(nv_done), .nv_error(nv_error));
  // ========================================
  // Shared tasks
  task check(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task bit_check(input string nm, input logic e, input logic g);
    check(nm, {15'h0000, e}, {15'h0000, g});
  endtask : bit_check
  task do_reset;
    reset_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
  endtask : do_reset
  // Returns in the answer cycle, so pulses are still visible
  task write_param(input logic [7:0] idx, input logic [15:0] v,
                   input logic ok);
    @(posedge clk_sys);
    #1;
    index = idx;
    wr_data = v;
    wr_en = 1'b1;
    @(posedge clk_sys);
    #1;
    wr_en = 1'b0;
    bit_check("wr_ack", ok, wr_ack);
    bit_check("wr_reject", !ok, wr_reject);
  endtask : write_param
  task read_param(input logic [7:0] idx, input logic [15:0] e,
                  input string nm);
    @(posedge clk_sys);
    #1;
    index = idx;
    rd_en = 1'b1;
    @(posedge clk_sys);
    #1;
    rd_en = 1'b0;
    bit_check("rd_valid", 1'b1, rd_valid);
    check(nm, e, rd_data);
  endtask : read_param
  task pulse_check(input logic e);
    bit_check("ref_loop_start", e, ref_loop_start);
    bit_check("centre_start", e, centre_start);
  endtask : pulse_check
  // ========================================
  // Scenarios
  task test_reset_values;
    read_param(IDX_CMD, RES_OK, "cmd_boot");
    read_param(IDX_GP_FIRST, GP_RESET, "gp_first");
    read_param(IDX_GP_LAST, GP_RESET, "gp_last");
    read_param(IDX_VOLT_LIM, 16'h00b9, "volt_lim");
    read_param(IDX_TEMP_LIM, 16'h0046, "temp_lim");
    read_param(8'hc0, 16'h0000, "unmapped");
    bit_check("fmt_active", FMT_SIX_BYTE, fmt_active);
    $display("test_reset_values done");
  endtask : test_reset_values
  task test_thresholds;
    motor_supply_voltage = 16'd185;
    temperature = 16'd70;
    repeat (3) @(posedge clk_sys);
    #1;
    bit_check("power", 1'b1, motor_power_present);
    bit_check("overtemp", 1'b0, overtemperature);
    motor_supply_voltage = 16'd184;
    temperature = 16'd71;
    repeat (3) @(posedge clk_sys);
    #1;
    bit_check("power", 1'b0, motor_power_present);
    bit_check("overtemp", 1'b1, overtemperature);
    write_param(IDX_VOLT_LIM, 16'd180, 1'b1);
    write_param(IDX_TEMP_LIM, 16'd71, 1'b0);
    write_param(IDX_TEMP_LIM, 16'd10, 1'b1);
    temperature = 16'd10;
    repeat (3) @(posedge clk_sys);
    #1;
    bit_check("power", 1'b1, motor_power_present);
    bit_check("overtemp", 1'b0, overtemperature);
    $display("test_thresholds done");
  endtask : test_thresholds
  task test_range_reject;
    write_param(IDX_VOLT_LIM, 16'd179, 1'b0);
    write_param(IDX_VOLT_LIM, 16'd241, 1'b0);
    write_param(IDX_TEMP_LIM, 16'd9, 1'b0);
    write_param(IDX_CMD, 16'h0004, 1'b0);
    write_param(IDX_CMD, 16'hfffd, 1'b0);
    write_param(8'hc0, 16'h0001, 1'b0);
    read_param(IDX_VOLT_LIM, 16'd180, "volt_lim");
    read_param(IDX_TEMP_LIM, 16'd10, "temp_lim");
    $display("test_range_reject done");
  endtask : test_range_reject
  task test_commands;
    write_param(IDX_GP_LAST, 16'h1234, 1'b1);
    write_param(IDX_CMD, CMD_NONE, 1'b1);
    pulse_check(1'b0);
    read_param(IDX_GP_LAST, 16'h1234, "gp_kept");
    write_param(IDX_CMD, CMD_FACT_KEEP, 1'b1);
    pulse_check(1'b0);
    read_param(IDX_GP_LAST, GP_RESET, "gp_restored");
    read_param(IDX_TEMP_LIM, 16'h0046, "temp_restored");
    bit_check("fmt_pending", 1'b0, fmt_pending);
    write_param(IDX_VOLT_LIM, 16'd220, 1'b1);
    write_param(IDX_CMD, CMD_FACT_FMT1, 1'b1);
    pulse_check(1'b0);
    read_param(IDX_VOLT_LIM, 16'h00b9, "volt_restored");
    bit_check("fmt_pending", 1'b1, fmt_pending);
    bit_check("fmt_active", 1'b0, fmt_active);
    restart_cmd = 1'b1;
    @(posedge clk_sys);
    #1;
    restart_cmd = 1'b0;
    @(posedge clk_sys);
    #1;
    bit_check("fmt_active", FMT_TIME_STAMP, fmt_active);
    write_param(IDX_VOLT_LIM, 16'd200, 1'b1);
    write_param(IDX_CMD, CMD_FACT_REF, 1'b1);
    pulse_check(1'b1);
    read_param(IDX_VOLT_LIM, 16'h00b9, "volt_restored");
    bit_check("fmt_pending", 1'b1, fmt_pending);
    write_param(IDX_CMD, CMD_FACT_ALL, 1'b1);
    pulse_check(1'b1);
    @(posedge clk_sys);
    #1;
    bit_check("fmt_pending", FMT_SIX_BYTE, fmt_pending);
    bit_check("fmt_active", FMT_TIME_STAMP, fmt_active);
    $display("test_commands done");
  endtask : test_commands
  task test_save(input logic fail, input logic slow, input logic mute,
                 input logic [15:0] res);
    int n;
    fail_mode = fail;
    slow_mode = slow;
    mute_mode = mute;
    write_param(IDX_CMD, CMD_SAVE, 1'b1);
    read_param(IDX_CMD, RES_BUSY, "cmd_busy");
    bit_check("nv_req", 1'b1, nv_req);
    n = 0;
    while (nv_req === 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    bit_check("save_ends", 1'b1, n < 1000);
    repeat (2) @(posedge clk_sys);
    read_param(IDX_CMD, res, "cmd_result");
    $display("test_save done");
  endtask : test_save
  task test_boot_fail;
    boot_mem_ok = 1'b0;
    fmt_stored = 1'b1;
    do_reset;
    read_param(IDX_CMD, RES_FAIL, "cmd_boot_bad");
    bit_check("fmt_active", FMT_TIME_STAMP, fmt_active);
    $display("test_boot_fail done");
  endtask : test_boot_fail
  // ========================================
  // Verdict
  task complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    do_reset;
    test_reset_values();
    test_thresholds();
    test_range_reject();
    test_commands();
    test_save(1'b0, 1'b0, 1'b0, RES_OK);
    test_save(1'b1, 1'b1, 1'b0, RES_FAIL);
    test_save(1'b0, 1'b0, 1'b1, RES_FAIL);
    test_boot_fail();
    complete_run();
  end
  // Tests need about 200 cycles; reaching the 10000-cycle limit means a hang
  initial begin
    #200000;
    error_cnt++;
    $display("Error watchdog expected finish seen hang");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
